//--- core/cllso_consts.svh
`ifndef CLLSO_CONSTS_SVH
`define CLLSO_CONSTS_SVH

// Byte offsets of the register map (one aligned word each).
`define CLLSO_OFS_INSTR 8'h00
`define CLLSO_OFS_STATUS 8'h04
`define CLLSO_OFS_WORK 8'h08
`define CLLSO_OFS_SP 8'h0c
`define CLLSO_OFS_BANK 8'h10
`define CLLSO_OFS_RAMADDR 8'h14
`define CLLSO_OFS_RAMDATA 8'h18
`define CLLSO_OFS_PC 8'h1c

// Status field positions.
`define CLLSO_ST_BUSY 0
`define CLLSO_ST_SKIP 1
`define CLLSO_ST_REFUSED 2
`define CLLSO_ST_BADOP 3

// Reset values.
`define CLLSO_RST_SP 8'h00
`define CLLSO_RST_PC 14'h0000
`define CLLSO_RST_NIB 4'h0

// Opcode bytes.
`define CLLSO_OPC_LD_DEC 8'h8b
`define CLLSO_OPC_LD_INC 8'h8a
`define CLLSO_OPC_IDLE 8'ha0
`define CLLSO_OPC_OR_MEM 8'h3a
`define CLLSO_OPC_PFX_DD 8'hdd
`define CLLSO_OPC_PFX_DC 8'hdc
`define CLLSO_OPC_HI_2 4'h2
`define CLLSO_OPC_POPSB2 8'h66
`define CLLSO_OPC_POPRR_HI 5'b00101

// Instruction lengths in bytes and times in instruction cycles.
`define CLLSO_LEN_1 2'd1
`define CLLSO_LEN_2 2'd2
`define CLLSO_CYC_LD 2'd2
`define CLLSO_CYC_IDLE 2'd1
`define CLLSO_CYC_OR_IMM 2'd2
`define CLLSO_CYC_OR_MEM 2'd1
`define CLLSO_CYC_OR_W 2'd2
`define CLLSO_CYC_POP_PAIR 2'd1
`define CLLSO_CYC_POP_SB 2'd2

// Stack step and pointer wrap values.
`define CLLSO_SP_STEP 8'h02
`define CLLSO_L_MIN 4'h0
`define CLLSO_L_MAX 4'hf

`endif

//--- core/cllso_pkg.sv
package cllso_pkg;

	// Decoded operation of one instruction.
	typedef enum logic [3:0] {
		CLLSO_OP_BAD = 4'h0,
		CLLSO_OP_LD_DEC = 4'h1,
		CLLSO_OP_LD_INC = 4'h2,
		CLLSO_OP_IDLE = 4'h3,
		CLLSO_OP_OR_IMM = 4'h4,
		CLLSO_OP_OR_MEM = 4'h5,
		CLLSO_OP_OR_WIDE = 4'h6,
		CLLSO_OP_OR_PAIR = 4'h7,
		CLLSO_OP_POP_PAIR = 4'h8,
		CLLSO_OP_POP_SB = 4'h9
	} cllso_op_t;

	// Sequencer state.
	typedef enum logic {
		CLLSO_IDLE = 1'b0,
		CLLSO_RUN = 1'b1
	} cllso_state_t;

endpackage : cllso_pkg

//--- core/cllso_decode.sv
`timescale 1ns/1ps
`include "cllso_consts.svh"

// Turns the two opcode bytes into an operation, length and cycle count.
module cllso_decode
	import cllso_pkg::*;
(
	input wire logic [7:0] op0, // First opcode byte.
	input wire logic [7:0] op1, // Second opcode byte.
	output cllso_op_t op, // Decoded operation.
	output logic [1:0] len, // Length in bytes.
	output logic [1:0] cyc, // Execution time in cycles.
	output logic [1:0] sel, // Register pair select.
	output logic [3:0] imm // Immediate nibble.
);

	// Pure decode; the sequencer registers the bytes, so no state lives here.
	always_comb
	begin
		op = CLLSO_OP_BAD;
		len = `CLLSO_LEN_1;
		cyc = `CLLSO_CYC_IDLE;
		sel = op1[2:1];
		imm = op1[3:0];
		case (op0)
			`CLLSO_OPC_LD_DEC:
			begin
				op = CLLSO_OP_LD_DEC;
				cyc = `CLLSO_CYC_LD;
			end
			`CLLSO_OPC_LD_INC:
			begin
				op = CLLSO_OP_LD_INC;
				cyc = `CLLSO_CYC_LD;
			end
			`CLLSO_OPC_IDLE:
			begin
				op = CLLSO_OP_IDLE;
				cyc = `CLLSO_CYC_IDLE;
			end
			`CLLSO_OPC_OR_MEM:
			begin
				op = CLLSO_OP_OR_MEM;
				cyc = `CLLSO_CYC_OR_MEM;
			end
			`CLLSO_OPC_PFX_DD:
			begin
				// Shared prefix: the second byte tells OR-immediate from bank pop.
				len = `CLLSO_LEN_2;
				if (op1[7:4] == `CLLSO_OPC_HI_2)
				begin
					op = CLLSO_OP_OR_IMM;
					cyc = `CLLSO_CYC_OR_IMM;
				end
				else if (op1 == `CLLSO_OPC_POPSB2)
				begin
					op = CLLSO_OP_POP_SB;
					cyc = `CLLSO_CYC_POP_SB;
				end
			end
			`CLLSO_OPC_PFX_DC:
			begin
				len = `CLLSO_LEN_2;
				if (op1[7:4] == `CLLSO_OPC_HI_2 && !op1[0])
				begin
					op = op1[3] ? CLLSO_OP_OR_WIDE : CLLSO_OP_OR_PAIR;
					cyc = `CLLSO_CYC_OR_W;
				end
			end
			default:
			begin
				// Pair pop carries its pair select in the first byte.
				if (op0[7:3] == `CLLSO_OPC_POPRR_HI && !op0[0])
				begin
					op = CLLSO_OP_POP_PAIR;
					cyc = `CLLSO_CYC_POP_PAIR;
					sel = op0[2:1];
				end
			end
		endcase
	end

endmodule : cllso_decode

//--- core/cllso_ram.sv
`timescale 1ns/1ps

// Nibble-wide data RAM with three read ports and one write port.
module cllso_ram
#(
	parameter int AW = 8 // Address width.
)
(
	input wire logic clk, // Core clock.
	input wire logic ce, // Clock enable.
	input wire logic we, // Write strobe.
	input wire logic [AW-1:0] waddr, // Write address.
	input wire logic [3:0] wdata, // Write nibble.
	input wire logic [AW-1:0] ra0, // Read address 0.
	input wire logic [AW-1:0] ra1, // Read address 1.
	input wire logic [AW-1:0] ra2, // Read address 2.
	output logic [3:0] rd0, // Read nibble 0.
	output logic [3:0] rd1, // Read nibble 1.
	output logic [3:0] rd2 // Read nibble 2.
);

	logic [3:0] mem [0:(1<<AW)-1]; // Storage; contents are not reset.

	// Only the software window writes; instructions here only read memory.
	always_ff @(posedge clk)
	begin
		if (ce && we)
		begin
			mem[waddr] <= wdata;
		end
	end

	// Asynchronous reads so an operand is ready in its first cycle.
	assign rd0 = mem[ra0];
	assign rd1 = mem[ra1];
	assign rd2 = mem[ra2];

endmodule : cllso_ram

//--- core/cllso_core.sv
`timescale 1ns/1ps
`include "cllso_consts.svh"

module cllso_core
	import cllso_pkg::*;
(
	input wire logic CLK, // Core clock, 250 MHz.
	input wire logic SYS_RST, // Synchronous reset, active high.
	input wire logic CE, // Clock enable; low freezes all state.
	input wire logic HSEL, // AHB slave select.
	input wire logic [31:0] HADDR, // AHB address.
	input wire logic [1:0] HTRANS, // AHB transfer type.
	input wire logic HWRITE, // AHB write flag.
	input wire logic [2:0] HSIZE, // AHB size, word only.
	input wire logic [31:0] HWDATA, // AHB write data.
	input wire logic HREADY, // AHB bus ready.
	output logic [31:0] HRDATA, // AHB read data.
	output logic HREADYOUT, // AHB slave ready.
	output logic HRESP // AHB response, always OKAY.
);

	cllso_state_t state_r; // Sequencer state.
	logic [15:0] instr_r; // Opcode bytes of the current instruction.
	logic first_r; // First cycle of an instruction.
	logic [1:0] cnt_r; // Cycles still to run.
	logic skip_r; // Next instruction is to be discarded.
	logic refused_r; // Sticky: instruction written while busy.
	logic badop_r; // Last executed (not skipped) instruction was not of this group.
	logic [13:0] pc_r; // Program counter.
	logic [3:0] nib_r [0:7]; // A,E,L,H,X,W,Z,Y working nibbles.
	logic [7:0] sp_r; // Stack pointer.
	logic [3:0] regbank_r; // Register bank select.
	logic [3:0] membank_r; // Memory bank select.
	logic [7:0] ramaddr_r; // Software window address into RAM.
	logic wr_pend_r; // Write data phase in progress.
	logic rd_pend_r; // Read wait state in progress.
	logic [7:0] addr_r; // Latched byte offset of the transfer.
	logic [31:0] hrdata_r; // Read data register.
	logic hreadyout_r; // Ready register.

	cllso_op_t op; // Decoded operation.
	logic [1:0] op_len; // Instruction length in bytes.
	logic [1:0] op_cyc; // Instruction time in cycles.
	logic [1:0] op_sel; // Pair select.
	logic [3:0] op_imm; // Immediate nibble.
	logic [3:0] ram_d0; // RAM nibble at pointer pair or stack pointer.
	logic [3:0] ram_d1; // RAM nibble at stack pointer plus one.
	logic [3:0] ram_dw; // RAM nibble at window address.
	logic [7:0] ra0; // Operand address.
	logic [7:0] sp_inc1; // Stack pointer plus one.
	logic addr_ok; // Address phase taken this edge.
	logic bus_wr; // Write data phase completes this edge.
	logic exec; // Instruction effects are applied this cycle.
	logic [1:0] run_cyc; // Cycles for the current instruction.
	logic [7:0] pair_v; // Value of the selected pair.
	logic [7:0] wacc_v; // Value of the wide accumulator.
	logic [7:0] or_v; // Wide OR result.
	logic [31:0] work_v; // Working nibbles packed for read-back.
	logic [31:0] rd_mux; // Read-back value for the latched offset.

	cllso_decode u_dec (
		.op0(instr_r[7:0]),
		.op1(instr_r[15:8]),
		.op(op),
		.len(op_len),
		.cyc(op_cyc),
		.sel(op_sel),
		.imm(op_imm)
	);

	// Pops address the stack; every other memory operand is at the pair.
	assign sp_inc1 = 8'(sp_r + 8'h01);
	assign ra0 = (op == CLLSO_OP_POP_PAIR || op == CLLSO_OP_POP_SB) ?
		sp_r : {nib_r[3], nib_r[2]};

	cllso_ram #(
		.AW(8)
	) u_ram (
		.clk(CLK),
		.ce(CE),
		.we(bus_wr && addr_r == `CLLSO_OFS_RAMDATA && state_r == CLLSO_IDLE),
		.waddr(ramaddr_r),
		.wdata(HWDATA[3:0]),
		.ra0(ra0),
		.ra1(sp_inc1),
		.ra2(ramaddr_r),
		.rd0(ram_d0),
		.rd1(ram_d1),
		.rd2(ram_dw)
	);

	// Bus handshake terms; only whole-word single transfers are expected.
	assign addr_ok = HSEL && HTRANS[1] && HREADY;
	assign bus_wr = wr_pend_r;
	assign exec = (state_r == CLLSO_RUN) && first_r && !skip_r;
	assign run_cyc = skip_r ? op_len : op_cyc;
	assign wacc_v = {nib_r[1], nib_r[0]};
	assign pair_v = {nib_r[{op_sel, 1'b1}], nib_r[{op_sel, 1'b0}]};
	assign or_v = pair_v | wacc_v;

	// AHB slave: writes finish with no wait; reads add one wait state so
	// a read that follows a write always sees the written value.
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
			hreadyout_r <= 1'b1;
		end
		else if (CE)
		begin
			wr_pend_r <= addr_ok && HWRITE;
			if (rd_pend_r)
			begin
				hrdata_r <= rd_mux;
				hreadyout_r <= 1'b1;
				rd_pend_r <= 1'b0;
			end
			else if (addr_ok && !HWRITE)
			begin
				hreadyout_r <= 1'b0;
				rd_pend_r <= 1'b1;
			end
			if (addr_ok)
			begin
				addr_r <= HADDR[7:0];
			end
		end
	end

	// Read-back mux; unmapped offsets read as zero.
	always_comb
	begin
		work_v = {nib_r[7], nib_r[6], nib_r[5], nib_r[4],
			nib_r[3], nib_r[2], nib_r[1], nib_r[0]};
		rd_mux = 32'h0000_0000;
		case (addr_r)
			`CLLSO_OFS_INSTR: rd_mux = {16'h0000, instr_r};
			`CLLSO_OFS_STATUS:
			begin
				rd_mux[`CLLSO_ST_BUSY] = (state_r == CLLSO_RUN);
				rd_mux[`CLLSO_ST_SKIP] = skip_r;
				rd_mux[`CLLSO_ST_REFUSED] = refused_r;
				rd_mux[`CLLSO_ST_BADOP] = badop_r;
			end
			`CLLSO_OFS_WORK: rd_mux = work_v;
			`CLLSO_OFS_SP: rd_mux = {24'h000000, sp_r};
			`CLLSO_OFS_BANK: rd_mux = {24'h000000, membank_r, regbank_r};
			`CLLSO_OFS_RAMADDR: rd_mux = {24'h000000, ramaddr_r};
			`CLLSO_OFS_RAMDATA: rd_mux = {28'h0000000, ram_dw};
			`CLLSO_OFS_PC: rd_mux = {18'h00000, pc_r};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Sequencer: a write to the instruction register starts one instruction;
	// it stays busy for its cycle count, or its length when skipped.
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			state_r <= CLLSO_IDLE;
			instr_r <= 16'h0000;
			first_r <= 1'b0;
			cnt_r <= 2'd0;
		end
		else if (CE)
		begin
			unique case (state_r)
				CLLSO_IDLE:
				begin
					if (bus_wr && addr_r == `CLLSO_OFS_INSTR)
					begin
						instr_r <= HWDATA[15:0];
						state_r <= CLLSO_RUN;
						first_r <= 1'b1;
					end
				end
				CLLSO_RUN:
				begin
					first_r <= 1'b0;
					if (first_r)
					begin
						cnt_r <= 2'(run_cyc - 2'd1);
						if (run_cyc == 2'd1)
						begin
							state_r <= CLLSO_IDLE;
						end
					end
					else if (cnt_r == 2'd1)
					begin
						state_r <= CLLSO_IDLE;
					end
					else
					begin
						cnt_r <= 2'(cnt_r - 2'd1);
					end
				end
			endcase
		end
	end

	// Status flags; a refusal in the cycle of its clear still sets it.
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			refused_r <= 1'b0;
			badop_r <= 1'b0;
		end
		else if (CE)
		begin
			if (bus_wr && addr_r == `CLLSO_OFS_INSTR && state_r == CLLSO_RUN)
			begin
				refused_r <= 1'b1;
			end
			else if (bus_wr && addr_r == `CLLSO_OFS_STATUS &&
				HWDATA[`CLLSO_ST_REFUSED])
			begin
				refused_r <= 1'b0;
			end
			if (exec)
			begin
				badop_r <= (op == CLLSO_OP_BAD);
			end
		end
	end

	// Program counter: every instruction, skipped or not, advances it.
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			pc_r <= `CLLSO_RST_PC;
		end
		else if (CE)
		begin
			if (state_r == CLLSO_RUN && first_r)
			begin
				pc_r <= 14'(pc_r + {12'h000, op_len});
			end
			else if (bus_wr && addr_r == `CLLSO_OFS_PC && state_r == CLLSO_IDLE)
			begin
				pc_r <= HWDATA[13:0];
			end
		end
	end

	// Skip flag: set by a pointer wrap, consumed by the next instruction.
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			skip_r <= 1'b0;
		end
		else if (CE && state_r == CLLSO_RUN && first_r)
		begin
			if (skip_r)
			begin
				skip_r <= 1'b0;
			end
			else if (op == CLLSO_OP_LD_DEC)
			begin
				skip_r <= (nib_r[2] == `CLLSO_L_MIN);
			end
			else if (op == CLLSO_OP_LD_INC)
			begin
				skip_r <= (nib_r[2] == `CLLSO_L_MAX);
			end
		end
	end

	// Working nibbles. Software may load them only while idle so that it
	// never races an instruction. There is no carry flag in this group,
	// so the loads cannot touch one.
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			for (int i = 0; i < 8; i++)
			begin
				nib_r[i] <= `CLLSO_RST_NIB;
			end
		end
		else if (CE)
		begin
			if (exec)
			begin
				unique case (op)
					CLLSO_OP_LD_DEC:
					begin
						nib_r[0] <= ram_d0;
						nib_r[2] <= 4'(nib_r[2] - 4'h1);
					end
					CLLSO_OP_LD_INC:
					begin
						nib_r[0] <= ram_d0;
						nib_r[2] <= 4'(nib_r[2] + 4'h1);
					end
					CLLSO_OP_OR_IMM: nib_r[0] <= nib_r[0] | op_imm;
					CLLSO_OP_OR_MEM: nib_r[0] <= nib_r[0] | ram_d0;
					CLLSO_OP_OR_WIDE:
					begin
						nib_r[0] <= or_v[3:0];
						nib_r[1] <= or_v[7:4];
					end
					CLLSO_OP_OR_PAIR:
					begin
						nib_r[{op_sel, 1'b0}] <= or_v[3:0];
						nib_r[{op_sel, 1'b1}] <= or_v[7:4];
					end
					CLLSO_OP_POP_PAIR:
					begin
						nib_r[{op_sel, 1'b0}] <= ram_d0;
						nib_r[{op_sel, 1'b1}] <= ram_d1;
					end
					CLLSO_OP_IDLE, CLLSO_OP_POP_SB, CLLSO_OP_BAD:
					begin
						// No working nibble changes.
					end
				endcase
			end
			else if (bus_wr && addr_r == `CLLSO_OFS_WORK && state_r == CLLSO_IDLE)
			begin
				for (int i = 0; i < 8; i++)
				begin
					nib_r[i] <= HWDATA[4*i +: 4];
				end
			end
		end
	end

	// Stack pointer, bank selects and the RAM window address.
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			sp_r <= `CLLSO_RST_SP;
			regbank_r <= `CLLSO_RST_NIB;
			membank_r <= `CLLSO_RST_NIB;
			ramaddr_r <= 8'h00;
		end
		else if (CE)
		begin
			if (exec && (op == CLLSO_OP_POP_PAIR || op == CLLSO_OP_POP_SB))
			begin
				sp_r <= 8'(sp_r + `CLLSO_SP_STEP);
				if (op == CLLSO_OP_POP_SB)
				begin
					regbank_r <= ram_d0;
					membank_r <= ram_d1;
				end
			end
			else if (bus_wr && state_r == CLLSO_IDLE)
			begin
				if (addr_r == `CLLSO_OFS_SP)
				begin
					sp_r <= HWDATA[7:0];
				end
				if (addr_r == `CLLSO_OFS_BANK)
				begin
					regbank_r <= HWDATA[3:0];
					membank_r <= HWDATA[7:4];
				end
				if (addr_r == `CLLSO_OFS_RAMADDR)
				begin
					ramaddr_r <= HWDATA[7:0];
				end
			end
		end
	end

	assign HRDATA = hrdata_r;
	assign HREADYOUT = hreadyout_r;
	assign HRESP = 1'b0;

endmodule : cllso_core

//--- tb/cllso_core_assertions.sv
`timescale 1ns/1ps

// Watches the slave port of the core; sees only its top-level ports.
module cllso_core_checker (
	input wire logic CLK, // Core clock.
	input wire logic SYS_RST, // Synchronous reset, active high.
	input wire logic CE, // Clock enable.
	input wire logic HSEL, // Slave select.
	input wire logic [31:0] HADDR, // Address.
	input wire logic [1:0] HTRANS, // Transfer type.
	input wire logic HWRITE, // Write flag.
	input wire logic [2:0] HSIZE, // Transfer size.
	input wire logic [31:0] HWDATA, // Write data.
	input wire logic HREADY, // Bus ready.
	input wire logic [31:0] HRDATA, // Read data.
	input wire logic HREADYOUT, // Slave ready.
	input wire logic HRESP // Response.
);
	// An address phase counts only while the core is clocked.
	wire tk = HSEL && HTRANS[1] && HREADY && CE;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);

	// The response never reports an error.
	a_resp_okay: assert property (HRESP == 1'b0)
		else $error("bus response not OKAY");
	// A read inserts exactly one wait cycle.
	a_read_wait: assert property (tk && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait cycle wrong");
	// A write completes with no wait.
	a_write_nowait: assert property (tk && HWRITE |=> HREADYOUT)
		else $error("write was stalled");
	// A wait never lasts longer than one cycle.
	a_wait_single: assert property (CE && !HREADYOUT |=> HREADYOUT)
		else $error("wait longer than one cycle");
	// Read data only changes at the end of a read wait cycle.
	a_rdata_hold: assert property (HREADYOUT |=> $stable(HRDATA))
		else $error("read data changed outside a read");
	// Reset leaves the port ready with cleared read data.
	a_reset_vals: assert property (disable iff (1'b0)
		SYS_RST && CE |=> HREADYOUT && HRDATA == 32'h0)
		else $error("port values after reset wrong");
	// With no transfer taken the slave stays ready.
	a_idle_ready: assert property (CE && HREADYOUT && !tk |=> HREADYOUT)
		else $error("slave stalled with no transfer");
	// Clock enable low freezes the slave outputs.
	a_ce_freeze: assert property (!CE |=> $stable(HRDATA) && $stable(HREADYOUT))
		else $error("outputs moved with enable low");

	c_read: cover property (tk && !HWRITE);
	c_instr: cover property (tk && HWRITE && HADDR[7:0] == 8'h00);
	c_frozen: cover property (!CE);
endmodule : cllso_core_checker

bind cllso_core cllso_core_checker u_cllso_core_checker (.CLK(CLK),
	.SYS_RST(SYS_RST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
	.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
	.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP));

//--- tb/cllso_stack_ref.sv
`timescale 1ns/1ps

// Shadow of the data and stack RAM, kept by snooping window writes.
module cllso_stack_ref (
	input wire logic clk, // Core clock.
	input wire logic hsel, // Slave select.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic [31:0] haddr, // Address.
	input wire logic hwrite, // Write flag.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready.
	input wire logic [7:0] sp, // Stack pointer to look up.
	output logic [3:0] lo, // Nibble at the stack pointer.
	output logic [3:0] hi // Nibble one above it.
);
	logic [3:0] mem [256]; // Shadow nibbles, unknown until written.
	logic ph_r; // A write data phase is in progress.
	logic [7:0] pa_r; // Its byte offset.
	logic [7:0] ra_r; // Shadow of the window address.

	// Pop reads the stack pointer slot and the one above it in the same cycle.
	assign lo = mem[sp];
	assign hi = mem[8'(sp + 8'h01)];

	// Writes never wait, so data always follows one cycle later.
	always_ff @(posedge clk)
	begin
		ph_r <= hsel && htrans[1] && hready && hwrite;
		pa_r <= haddr[7:0];
		if (ph_r && pa_r == 8'h14)
			ra_r <= hwdata[7:0];
		if (ph_r && pa_r == 8'h18)
			mem[ra_r] <= hwdata[3:0];
	end
endmodule : cllso_stack_ref

//--- tb/test_cpu_load_logic_stack_ops.sv
`timescale 1ns/1ps

// Runs the instruction group through the register window.
module test_cpu_load_logic_stack_ops;
	logic clk = 1'b0; // Core clock.
	logic rst = 1'b1; // Synchronous reset.
	logic ce = 1'b1; // Clock enable.
	logic hsel = 1'b0; // Slave select.
	logic [31:0] haddr = 32'h0; // Address.
	logic [1:0] htrans = 2'b00; // Transfer type.
	logic hwrite = 1'b0; // Write flag.
	logic [31:0] hwdata = 32'h0; // Write data.
	logic [31:0] hrdata; // Read data.
	logic hreadyout; // Slave ready, also the bus ready.
	logic hresp; // Response.
	logic [7:0] sp = 8'h0; // Stack slot looked up in the shadow.
	logic [3:0] lo; // Shadow nibble at sp.
	logic [3:0] hi; // Shadow nibble at sp plus one.
	int n_errors = 0; // Mismatches seen.
	int comparisons = 0; // Comparisons made.

	always #2 clk = ~clk;

	cllso_core u_cllso_core (.CLK(clk), .SYS_RST(rst), .CE(ce), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010),
		.HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp));

	cllso_stack_ref u_cllso_stack_ref (.clk(clk), .hsel(hsel), .htrans(htrans),
		.haddr(haddr), .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout),
		.sp(sp), .lo(lo), .hi(hi));

	// Prints the counts and the verdict, then stops.
	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	// Compares one word read back.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	// One single transfer; the wait on ready is bounded.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int i;
		i = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1 && ++i < 50);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1 && ++i < 50);
		q = hrdata;
		if (i >= 50)
		begin
			n_errors++;
			results();
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rd

	// Puts one nibble into data RAM through the window.
	task automatic ram(input logic [7:0] a, input logic [3:0] d);
		wr(8'h14, {24'h0, a});
		wr(8'h18, {28'h0, d});
	endtask : ram

	// Starts one instruction and polls until it is no longer busy.
	task automatic run(input logic [15:0] ins);
		logic [31:0] q;
		int i;
		i = 0;
		wr(8'h00, {16'h0, ins});
		do bus(1'b0, 8'h04, 32'h0, q); while (q[0] !== 1'b0 && ++i < 20);
		if (i >= 20)
		begin
			n_errors++;
			results();
		end
	endtask : run

	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(8'h0c, 32'h0);
		rd(8'h1c, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h40, 32'h0);
		// Decrement from zero borrows and skips the next load.
		ram(8'h20, 4'hf);
		wr(8'h08, 32'h2000);
		run(16'h008b);
		rd(8'h08, 32'h2f0f);
		rd(8'h04, 32'h2);
		rd(8'h18, 32'hf);
		run(16'h008a);
		rd(8'h08, 32'h2f0f);
		rd(8'h1c, 32'h2);
		rd(8'h04, 32'h0);
		// Increment from F overflows and skips a two-byte OR.
		ram(8'h2f, 4'ha);
		wr(8'h08, 32'h2f00);
		run(16'h008a);
		rd(8'h08, 32'h200a);
		rd(8'h04, 32'h2);
		run(16'h25dd);
		rd(8'h08, 32'h200a);
		rd(8'h1c, 32'h5);
		run(16'h25dd);
		rd(8'h08, 32'h200f);
		rd(8'h1c, 32'h7);
		// Decrement without borrow, then OR with memory.
		ram(8'h21, 4'h3);
		ram(8'h20, 4'h4);
		wr(8'h08, 32'h2100);
		run(16'h008b);
		rd(8'h08, 32'h2003);
		rd(8'h04, 32'h0);
		run(16'h003a);
		rd(8'h08, 32'h2007);
		rd(8'h18, 32'h4);
		// Wide OR in both directions.
		wr(8'h08, 32'h0012_5a31);
		run(16'h2adc);
		rd(8'h08, 32'h0012_5a7b);
		run(16'h24dc);
		rd(8'h08, 32'h007b_5a7b);
		// Pair pop, then bank pop from the slots above.
		ram(8'hed, 4'h4);
		ram(8'hee, 4'h3);
		ram(8'hef, 4'h5);
		ram(8'hf0, 4'h9);
		wr(8'h0c, 32'hed);
		wr(8'h08, 32'h0);
		sp <= 8'hed;
		run(16'h002a);
		rd(8'h08, {16'h0, hi, lo, 8'h0});
		rd(8'h0c, 32'hef);
		sp <= 8'hef;
		run(16'h66dd);
		rd(8'h10, {24'h0, hi, lo});
		rd(8'h0c, 32'hf1);
		// Idle op moves only the program counter.
		wr(8'h1c, 32'h10);
		run(16'h00a0);
		rd(8'h08, 32'h3400);
		rd(8'h1c, 32'h11);
		// Software keeps three idle ops in a row, as after a stop.
		repeat (3) run(16'h00a0);
		rd(8'h1c, 32'h14);
		// A start while busy is refused; an unknown code is flagged.
		wr(8'h00, 32'h20dd);
		wr(8'h00, 32'hff);
		rd(8'h04, 32'h4);
		wr(8'h04, 32'h4);
		run(16'h00ff);
		rd(8'h04, 32'h8);
		rd(8'h08, 32'h3400);
		// Enable low freezes the core for a few cycles.
		ce <= 1'b0;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		rd(8'h0c, 32'hf1);
		results();
	end
endmodule : test_cpu_load_logic_stack_ops
